/* File: common/rss_pkg.sv */
package rss_pkg;

  localparam int NUM_RAILS = 6;

  // clock and timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 10000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // sequence times in their own units
  localparam int WAKE_US      = 100;
  localparam int DLY_BASE_US  = 250;
  localparam int REL_BASE_US  = 1000;
  localparam int RECOV_MS     = 32;

  // the same times as timebase ticks
  localparam logic [13:0] WAKE_TICKS     = 14'(WAKE_US * 1000 / TICK_NS);
  localparam logic [13:0] DLY_BASE_TICKS = 14'(DLY_BASE_US * 1000 / TICK_NS);
  localparam logic [13:0] REL_BASE_TICKS = 14'(REL_BASE_US * 1000 / TICK_NS);
  localparam logic [13:0] RECOV_TICKS    = 14'(RECOV_MS * 1000000 / TICK_NS);

  // register byte offsets
  localparam logic [7:0] OFS_RELEASE_CFG = 8'h00;
  localparam logic [7:0] OFS_STATUS      = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT    = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h0C;
  localparam logic [7:0] OFS_RAIL_BASE   = 8'h10;

  // field positions
  localparam int RLS_SEL_LSB   = 0;
  localparam int STS_STATE_LSB = 0;
  localparam int STS_STEP_LSB  = 4;
  localparam int STS_EN_LSB    = 8;
  localparam int STS_GOOD_LSB  = 16;
  localparam int STS_RST_BIT   = 24;
  localparam int IRQ_START     = 0;
  localparam int IRQ_DONE      = 1;
  localparam int IRQ_ABORT     = 2;
  localparam int IRQ_W         = 3;

  // reset values
  localparam logic [2:0]       RELEASE_SEL_RST = 3'h4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST    = 3'h7;

  typedef struct packed {
    logic       mode_on;
    logic       rsvd;
    logic [2:0] dly;
    logic [1:0] seq_step_sel;
    logic       seq_include;
  } rss_rail_cfg_t;

  localparam logic [7:0] RAIL_CFG_RST [NUM_RAILS] = '{8'h89, 8'hAB, 8'hA5, 8'hA5, 8'h89, 8'h00};

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_STEP    = 3'b001,
    ST_RELEASE = 3'b010,
    ST_ON      = 3'b011
  } rss_state_t;

endpackage

/* File: verilog/rss_sequencer.sv */
// Contract
// - button start counts only if held low until the first step-1 rail starts
// - rising power_hold starts a sequence regardless of the button
// - button start needs power_hold high at release time, else turn off
// - after step one starts, button toggles are ignored but still mirrored
// - three steps; included rails placed by step selector 00, 01, 1x
// - step-1 rails start after delay; invalid start event aborts first
// - step-2 delay counts from all step-1 rails good
// - step-3 delay counts from all step-1 and step-2 rails good
// - each rail times its own start from its own delay field
// - step-1 delays add the roughly 100 us wake-up time
// - default delays 0.5 ms, 8 ms and 4 ms for steps one to three
// - release delay from last step good, default code 100 gives 16 ms
// - included rails checked before and after release delay; others ignored
// - after release, mode-on bits set rail enables
// - a rail failing during the steps gets 32 ms to recover, then abort to off
// - bypass-ok rails count good during start-up; raw good reported after
`timescale 1ns/1ps
module rss_sequencer #(
  parameter int TICK_CYCLES = rss_pkg::TICK_CYCLES
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          start_button_n,
  input  wire logic                          power_hold,
  input  wire logic [rss_pkg::NUM_RAILS-1:0] rail_good,
  input  wire logic [rss_pkg::NUM_RAILS-1:0] rail_bypass_ok,
  output logic      [rss_pkg::NUM_RAILS-1:0] rail_en,
  output logic                               start_mirror_out_n,
  output logic                               host_reset_out_n,
  output logic                               host_reset_oe_n,
  output logic                               irq
);
  import rss_pkg::*;

  localparam int NR = NUM_RAILS;

  function automatic logic [1:0] step_of(input logic [1:0] sel);
    // step 3 takes both 10 and 11
    step_of = sel[1] ? 2'h3 : (sel[0] ? 2'h2 : 2'h1);
  endfunction

  function automatic logic [13:0] pow2_ticks(input logic [13:0] base, input logic [2:0] code);
    pow2_ticks = base << code;
  endfunction

  rss_state_t             state_q, state_d;
  rss_rail_cfg_t [NR-1:0] cfg_q;
  logic [1:0]             step_q, step_d;
  logic                   src_btn_q, src_btn_d;
  logic                   first_on_q, first_on_d;
  logic [NR-1:0]          en_q, en_d;
  logic [13:0]            timer_q;
  logic [13:0]            fail_q;
  logic [15:0]            div_q;
  logic                   tick;
  logic                   restart;
  logic                   ph_prev_q;
  logic                   btn_armed_q;
  logic                   mirror_q;
  logic                   rel_q;
  logic [2:0]             release_sel_q;
  logic [IRQ_W-1:0]       irq_stat_q;
  logic [IRQ_W-1:0]       irq_mask_q;
  logic [IRQ_W-1:0]       irq_ev;
  logic [31:0]            prdata_q;
  logic                   pslverr_q;

  // timebase tick
  // single timebase
  assign tick = (div_q == 16'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
    end else if (tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // sequence decode
  logic [NR-1:0] in_step;
  logic [NR-1:0] due;
  logic [NR-1:0] done_mask;
  logic [NR-1:0] incl_vec;
  logic [NR-1:0] mode_on_vec;
  logic [NR-1:0] ok_vec;
  logic          all_started;
  logic          step_good;
  logic          all_incl_good;
  logic          start_valid;
  logic          ph_rise;
  logic          btn_press;
  logic          dbg_abort;
  logic          fail_exp;
  logic          rel_exp;

  assign ok_vec = rail_good | rail_bypass_ok;

  for (genvar i = 0; i < NR; i++) begin : g_rail
    assign in_step[i]     = cfg_q[i].seq_include && (step_of(cfg_q[i].seq_step_sel) == step_q);
    assign done_mask[i]   = cfg_q[i].seq_include && (step_of(cfg_q[i].seq_step_sel) <= step_q);
    assign incl_vec[i]    = cfg_q[i].seq_include;
    assign mode_on_vec[i] = cfg_q[i].mode_on;
    assign due[i] = in_step[i] && (timer_q >= (pow2_ticks(DLY_BASE_TICKS, cfg_q[i].dly)
                    + ((step_q == 2'h1) ? WAKE_TICKS : 14'h0000)));
  end

  assign all_started   = &(~in_step | en_q);
  assign step_good     = &(~done_mask | ok_vec);
  assign all_incl_good = &(~incl_vec | ok_vec);
  assign start_valid   = src_btn_q ? ~start_button_n : power_hold;
  assign ph_rise       = power_hold && !ph_prev_q;
  assign btn_press     = btn_armed_q && !start_button_n;
  // start event must hold until the first rail starts
  assign dbg_abort     = (step_q == 2'h1) && !first_on_q && !start_valid;
  assign fail_exp      = (fail_q >= RECOV_TICKS);
  assign rel_exp       = (timer_q >= pow2_ticks(REL_BASE_TICKS, release_sel_q));

  always_comb begin
    state_d    = state_q;
    step_d     = step_q;
    src_btn_d  = src_btn_q;
    first_on_d = first_on_q;
    en_d       = en_q;
    restart    = 1'b0;
    irq_ev     = '0;
    case (state_q)
      ST_OFF: begin
        en_d       = '0;
        first_on_d = 1'b0;
        step_d     = 2'h1;
        if (ph_rise) begin
          state_d           = ST_STEP;
          src_btn_d         = 1'b0;
          restart           = 1'b1;
          irq_ev[IRQ_START] = 1'b1;
        end else if (btn_press) begin
          state_d           = ST_STEP;
          src_btn_d         = 1'b1;
          restart           = 1'b1;
          irq_ev[IRQ_START] = 1'b1;
        end
      end
      ST_STEP: begin
        // abort before switching on, or after failed recovery
        if (dbg_abort || fail_exp) begin
          state_d           = ST_OFF;
          en_d              = '0;
          irq_ev[IRQ_ABORT] = 1'b1;
        end else begin
          en_d       = en_q | due;
          first_on_d = first_on_q | (|due);
          // next step timer starts from step good
          if (all_started && step_good) begin
            restart = 1'b1;
            if (step_q == 2'h3) begin
              state_d = ST_RELEASE;
            end else begin
              step_d = step_q + 2'h1;
            end
          end
        end
      end
      ST_RELEASE: begin
        if (rel_exp) begin
          // second check and power_hold at release time
          if (all_incl_good && power_hold) begin
            state_d          = ST_ON;
            en_d             = mode_on_vec;
            irq_ev[IRQ_DONE] = 1'b1;
          end else begin
            state_d           = ST_OFF;
            en_d              = '0;
            irq_ev[IRQ_ABORT] = 1'b1;
          end
        end
      end
      ST_ON: begin
        en_d = mode_on_vec;
        if (!power_hold) begin
          state_d = ST_OFF;
          en_d    = '0;
        end
      end
      default: begin
        state_d = ST_OFF;
        en_d    = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_OFF;
      step_q     <= 2'h1;
      src_btn_q  <= 1'b0;
      first_on_q <= 1'b0;
      en_q       <= '0;
      rel_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      step_q     <= step_d;
      src_btn_q  <= src_btn_d;
      first_on_q <= first_on_d;
      en_q       <= en_d;
      // reset released only on entry to on, never a glitch
      rel_q      <= (state_d == ST_ON);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= 14'h0000;
    end else if (restart) begin
      timer_q <= 14'h0000;
    end else if (tick && (timer_q != 14'h3FFF)) begin
      timer_q <= timer_q + 14'h0001;
    end
  end

  // counts only while a started rail is not yet good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_q <= 14'h0000;
    end else if (restart || (state_q != ST_STEP) || !(all_started && !step_good)) begin
      fail_q <= 14'h0000;
    end else if (tick) begin
      fail_q <= fail_q + 14'h0001;
    end
  end

  // button re-arms only once released in off, so a held button cannot loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_prev_q   <= 1'b0;
      btn_armed_q <= 1'b0;
      mirror_q    <= 1'b1;
    end else begin
      ph_prev_q <= power_hold;
      mirror_q  <= start_button_n;
      if (state_q != ST_OFF) begin
        btn_armed_q <= 1'b0;
      end else if (start_button_n) begin
        btn_armed_q <= 1'b1;
      end
    end
  end

  assign rail_en            = en_q;
  assign start_mirror_out_n = mirror_q;
  assign host_reset_out_n   = 1'b0;
  assign host_reset_oe_n    = rel_q;

  // register bus
  logic        wr_en;
  logic        rd_setup;
  logic        hit_rls;
  logic        hit_sts;
  logic        hit_ist;
  logic        hit_msk;
  logic        hit_rail;
  logic [7:0]  rail_ofs;
  logic [2:0]  rail_idx;
  logic        addr_ok;
  logic [31:0] rdata;
  logic [31:0] status_word;

  assign rail_ofs = paddr - OFS_RAIL_BASE;
  assign rail_idx = rail_ofs[4:2];
  assign hit_rls  = (paddr == OFS_RELEASE_CFG);
  assign hit_sts  = (paddr == OFS_STATUS);
  assign hit_ist  = (paddr == OFS_IRQ_STAT);
  assign hit_msk  = (paddr == OFS_IRQ_MASK);
  assign hit_rail = (paddr >= OFS_RAIL_BASE) && (rail_ofs[1:0] == 2'h0) && (rail_ofs[7:2] < 6'(NR));
  assign addr_ok  = hit_rls || hit_sts || hit_ist || hit_msk || hit_rail;
  assign wr_en    = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable;

  // raw good reported, bypass not folded in
  assign status_word = (32'(state_q) << STS_STATE_LSB) | (32'(step_q) << STS_STEP_LSB)
                     | (32'(en_q) << STS_EN_LSB) | (32'(rail_good) << STS_GOOD_LSB)
                     | (32'(rel_q) << STS_RST_BIT);

  assign rdata = hit_rls  ? (32'(release_sel_q) << RLS_SEL_LSB) :
                 hit_sts  ? status_word :
                 hit_ist  ? 32'(irq_stat_q) :
                 hit_msk  ? 32'(irq_mask_q) :
                 hit_rail ? 32'(cfg_q[rail_idx] & 8'hBF) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (rd_setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rdata;
      pslverr_q <= !addr_ok;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q && psel && penable;
  assign pready  = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      release_sel_q <= RELEASE_SEL_RST;
      irq_mask_q    <= IRQ_MASK_RST;
      for (int i = 0; i < NR; i++) begin
        cfg_q[i] <= rss_rail_cfg_t'(RAIL_CFG_RST[i]);
      end
    end else if (wr_en) begin
      if (hit_rls) begin
        release_sel_q <= pwdata[RLS_SEL_LSB +: 3];
      end
      if (hit_msk) begin
        irq_mask_q <= pwdata[IRQ_W-1:0];
      end
      if (hit_rail) begin
        cfg_q[rail_idx] <= rss_rail_cfg_t'(pwdata[7:0] & 8'hBF);
      end
    end
  end

  // sticky status; a new event wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (wr_en && hit_ist) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  assign irq = |(irq_stat_q & ~irq_mask_q);

endmodule

/* File: dv/rss_sequencer_assertions.sv */
`timescale 1ns/1ps
module rss_chk #(
  parameter int TICK_CYCLES = rss_pkg::TICK_CYCLES
) (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic                          start_button_n,
  input wire logic                          power_hold,
  input wire logic [rss_pkg::NUM_RAILS-1:0] rail_good,
  input wire logic [rss_pkg::NUM_RAILS-1:0] rail_bypass_ok,
  input wire logic [rss_pkg::NUM_RAILS-1:0] rail_en,
  input wire logic                          start_mirror_out_n,
  input wire logic                          host_reset_out_n,
  input wire logic                          host_reset_oe_n
);
  import rss_pkg::*;
  // small slack covers the tick phase at which the recovery timer starts
  localparam logic [31:0] BAD_LIM = 32'((int'(RECOV_TICKS) + 4) * TICK_CYCLES);
  logic [31:0] bad_q;
  logic [31:0] bad_d;
  wire         rail_bad = |(rail_en & ~(rail_good | rail_bypass_ok));
  assign bad_d = (rail_bad && !host_reset_oe_n) ? bad_q + 32'h1 : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_q <= 32'h0;
    end else begin
      bad_q <= bad_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_mirror_follow: assert property (start_mirror_out_n == $past(start_button_n))
    else $error("start mirror does not follow the button");
  a_reset_drive_low: assert property (host_reset_out_n == 1'b0)
    else $error("reset pin drive value is not low");
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  a_slverr_access: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  a_release_hold: assert property ($rose(host_reset_oe_n) |-> $past(power_hold))
    else $error("reset released without power hold");
  a_release_rails: assert property ($rose(host_reset_oe_n) |-> |$past(rail_en))
    else $error("reset released with no rail running");
  a_button_debounce: assert property ($rose(|rail_en) && !$past(power_hold) |-> !$past(start_button_n))
    else $error("button start without a held press");
  a_recovery_bound: assert property (bad_q <= BAD_LIM)
    else $error("failed rail kept beyond recovery wait");
endmodule
bind rss_sequencer rss_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .start_button_n(start_button_n), .power_hold(power_hold), .rail_good(rail_good),
  .rail_bypass_ok(rail_bypass_ok), .rail_en(rail_en), .start_mirror_out_n(start_mirror_out_n),
  .host_reset_out_n(host_reset_out_n), .host_reset_oe_n(host_reset_oe_n)
);

/* File: dv/rss_rail_model.sv */
`timescale 1ns/1ps
module rss_rail_model #(
  parameter int GOOD_DLY = 3
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [rss_pkg::NUM_RAILS-1:0] rail_en,
  input  wire logic [rss_pkg::NUM_RAILS-1:0] fail_mask,
  output logic      [rss_pkg::NUM_RAILS-1:0] rail_good
);
  import rss_pkg::*;
  logic [NUM_RAILS-1:0] ramp_q [GOOD_DLY];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_q <= '{default: '0};
    end else begin
      ramp_q[0] <= rail_en;
      for (int i = 1; i < GOOD_DLY; i++) begin
        ramp_q[i] <= ramp_q[i-1] & rail_en;
      end
    end
  end
  // a disabled rail drops at once, so a stale good never leaks
  assign rail_good = ramp_q[GOOD_DLY-1] & rail_en & ~fail_mask;
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import rss_pkg::*;
  localparam int TC  = 4;
  localparam int GD  = 3;
  localparam int TOL = 3 * TC + 8;
  localparam int D   = int'(DLY_BASE_TICKS);
  localparam int W   = int'(WAKE_TICKS);
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic                 start_button_n, power_hold, start_mirror_out_n, host_reset_out_n, host_reset_oe_n;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [NUM_RAILS-1:0] rail_good, rail_bypass_ok, rail_en, fail_mask;
  logic [6:0]           seen;
  int                   failures, samples_checked, cyc, n;
  rss_sequencer #(.TICK_CYCLES(TC)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_button_n(start_button_n),
    .power_hold(power_hold), .rail_good(rail_good), .rail_bypass_ok(rail_bypass_ok), .rail_en(rail_en),
    .start_mirror_out_n(start_mirror_out_n), .host_reset_out_n(host_reset_out_n),
    .host_reset_oe_n(host_reset_oe_n), .irq(irq)
  );
  rss_rail_model #(.GOOD_DLY(GD)) u_rails (
    .pclk(pclk), .presetn(presetn), .rail_en(rail_en), .fail_mask(fail_mask), .rail_good(rail_good)
  );
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic near(input string what, input int exp);
    samples_checked++;
    if (n < exp - TOL || n > exp + TOL) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, n);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // the access phase lasts until ready is seen high at a rising edge
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge keeps a following call from raising psel in the step it fell
    @(posedge pclk);
  endtask
  task automatic wait_en(input logic [6:0] m, input logic [6:0] v, input int lim);
    n = 0;
    while (n < lim) begin
      @(negedge pclk);
      seen = {host_reset_oe_n, rail_en};
      if ((seen & m) === v) break;
      n++;
    end
    @(posedge pclk);
  endtask
  task automatic chk_irq(input logic exp);
    @(negedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
    @(posedge pclk);
  endtask
  task automatic t_regs();
    for (int i = 0; i < NUM_RAILS; i++) begin
      apb(1'b0, OFS_RAIL_BASE + 8'(4 * i), 32'h0);
      chk("rail cfg reset", {24'h0, RAIL_CFG_RST[i]}, rd);
    end
    apb(1'b0, OFS_RELEASE_CFG, 32'h0);
    chk("release sel reset", 32'(RELEASE_SEL_RST), rd);
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("irq mask reset", 32'(IRQ_MASK_RST), rd);
    apb(1'b1, OFS_RAIL_BASE + 8'h14, 32'hFF);
    apb(1'b0, OFS_RAIL_BASE + 8'h14, 32'h0);
    chk("reserved bit", 32'hBF, rd);
    apb(1'b0, 8'hF0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask
  task automatic t_hold();
    apb(1'b1, OFS_RAIL_BASE + 8'h14, 32'h80);
    apb(1'b1, OFS_RAIL_BASE + 8'h10, 32'h91);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    fail_mask <= 6'h01;
    rail_bypass_ok <= 6'h01;
    power_hold <= 1'b1;
    wait_en(7'h01, 7'h01, 2000);
    near("step1 first", ((D << 1) + W) * TC);
    chk("step1 early", 32'h01, 32'(seen));
    wait_en(7'h10, 7'h10, 2000);
    near("step1 second", ((D << 2) - (D << 1)) * TC);
    wait_en(7'h02, 7'h02, 9000);
    near("step2", (D << 5) * TC + GD);
    chk("step2 rails", 32'h13, 32'(seen));
    wait_en(7'h0C, 7'h0C, 9000);
    near("step3", (D << 4) * TC + GD);
    wait_en(7'h40, 7'h40, 9000);
    near("release", (int'(REL_BASE_TICKS) << 4) * TC + GD);
    repeat (GD + 2) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("mode on rails", 32'h3F, (rd >> STS_EN_LSB) & 32'h3F);
    chk("raw good", 32'h3E, (rd >> STS_GOOD_LSB) & 32'h3F);
    chk_irq(1'b1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq stat done", 32'h3, rd);
    apb(1'b1, OFS_IRQ_STAT, 32'h3);
    chk_irq(1'b0);
    power_hold <= 1'b0;
    fail_mask <= 6'h00;
    rail_bypass_ok <= 6'h00;
    wait_en(7'h7F, 7'h00, 50);
    chk("off after hold drop", 32'h0, 32'(seen));
  endtask
  task automatic t_btn();
    apb(1'b1, OFS_RELEASE_CFG, 32'h0);
    start_button_n <= 1'b0;
    wait_en(7'h01, 7'h01, 2000);
    near("button step1", ((D << 1) + W) * TC);
    start_button_n <= 1'b1;
    repeat (7) @(posedge pclk);
    start_button_n <= 1'b0;
    repeat (7) @(posedge pclk);
    chk("start mirror", 32'h0, {31'h0, start_mirror_out_n});
    start_button_n <= 1'b1;
    wait_en(7'h0C, 7'h0C, 9000);
    chk("sequence kept", 32'h1F, 32'(seen));
    wait_en(7'h7F, 7'h00, 9000);
    near("turn off", int'(REL_BASE_TICKS) * TC + GD);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("abort flag", 32'h4, rd & 32'h6);
    apb(1'b1, OFS_IRQ_STAT, 32'h7);
  endtask
  task automatic t_short();
    apb(1'b1, OFS_IRQ_MASK, 32'h7);
    start_button_n <= 1'b0;
    repeat (100) @(posedge pclk);
    start_button_n <= 1'b1;
    wait_en(7'h01, 7'h01, 400);
    chk("short press", 32'd400, 32'(n));
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("abort flag", 32'h4, rd & 32'h4);
    chk_irq(1'b0);
    apb(1'b1, OFS_IRQ_STAT, 32'h7);
  endtask
  task automatic t_fail();
    apb(1'b1, OFS_RAIL_BASE + 8'h10, 32'h89);
    fail_mask <= 6'h01;
    power_hold <= 1'b1;
    wait_en(7'h11, 7'h11, 2000);
    wait_en(7'h7F, 7'h00, 16000);
    near("recovery wait", int'(RECOV_TICKS) * TC);
    power_hold <= 1'b0;
    fail_mask <= 6'h00;
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("abort flag", 32'h4, rd & 32'h4);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    start_button_n = 1'b1;
    power_hold = 1'b0;
    rail_bypass_ok = 6'h00;
    fail_mask = 6'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_hold();
    t_btn();
    t_short();
    t_fail();
    end_sim();
  end
endmodule
